// ---- bench/one_hot_select_mux_tb.sv ----
// Self-checking bench for the one-hot select multiplexer with four lanes.
// Assumes one cycle of latency from inputs to every registered output.
`timescale 1ns/1ps
module one_hot_select_mux_tb;
    localparam int LANES = 4;
    logic ref_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic invert_i = 1'b0;
    logic clear_status_i = 1'b0;
    logic break_i = 1'b0;
    logic [7:0] lane = 8'h00;
    logic [LANES-1:0] raw_sel = 4'h0;
    logic [LANES-1:0] word = 4'h0;
    logic [LANES-1:0] sel;
    logic [LANES-1:0] data;
    logic mux_out, defined, contention, none_seen, many_seen;
    logic [one_hot_select_pkg::ERR_CNT_W-1:0] err_count;
    logic [7:0] flags;
    int num_errors = 0;
    int samples_checked = 0;

    // Flags packed as {mux, defined, contention, none seen, many seen}.
    assign flags = {3'h0, mux_out, defined, contention, none_seen, many_seen};

    // Free-running clock at 25 MHz.
    always #20 ref_clk_i = ~ref_clk_i;

    upstream_model #(.LANES(LANES)) model (.lane_i(lane), .break_i(break_i), .raw_sel_i(raw_sel),
        .word_i(word), .sel_o(sel), .data_o(data));

    one_hot_select_mux #(.LANES(LANES)) uut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .sel_i(sel),
        .data_i(data), .invert_i(invert_i), .clear_status_i(clear_status_i), .mux_out_o(mux_out),
        .out_defined_o(defined), .contention_o(contention), .none_seen_o(none_seen),
        .many_seen_o(many_seen), .err_count_o(err_count));

    // Compares one value and counts the outcome.
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Drives one input set; it is sampled at two edges, so a forbidden set counts twice.
    task automatic step(input logic brk, input logic [7:0] ln, input logic [3:0] rs,
        input logic [3:0] w, input logic inv, input logic clr);
        @(posedge ref_clk_i);
        break_i <= brk;
        lane <= ln;
        raw_sel <= rs;
        word <= w;
        invert_i <= inv;
        clear_status_i <= clr;
        @(posedge ref_clk_i);
        #1;
    endtask

    // Every lane, every data word and both polarities with a legal select.
    task automatic one_hot_sweep();
        for (int inv = 0; inv < 2; inv++)
            for (int ln = 0; ln < LANES; ln++)
                for (int w = 0; w < 16; w++)
                begin
                    step(1'b0, 8'(ln), 4'h0, 4'(w), 1'(inv), 1'b0);
                    check("sweep flags", {3'h0, 1'(((w >> ln) & 1) ^ inv), 4'h8}, flags);
                end
    endtask

    // Same lane and data with only the polarity flipped: the whole result inverts.
    task automatic polarity_toggle();
        step(1'b0, 8'h01, 4'h0, 4'h2, 1'b0, 1'b0);
        check("polarity plain", 8'h18, flags);
        step(1'b0, 8'h01, 4'h0, 4'h2, 1'b1, 1'b0);
        check("polarity inverted", 8'h08, flags);
    endtask

    // No select high, then two selects high; status accumulates.
    // Each check follows the first edge of a new set, so only the earlier sets have counted twice.
    task automatic forbidden_patterns();
        step(1'b1, 8'h00, 4'h0, 4'hF, 1'b1, 1'b0);
        check("none flags", 8'h16, flags);
        check("none count", 8'h01, err_count);
        step(1'b1, 8'h00, 4'h3, 4'h1, 1'b0, 1'b0);
        check("many flags", 8'h17, flags);
        check("many count", 8'h03, err_count);
    endtask

    // Clear with a legal select, then clear against a forbidden one, then saturation.
    task automatic status_clear();
        step(1'b0, 8'h02, 4'h0, 4'h0, 1'b0, 1'b1);
        check("clear flags", 8'h08, flags);
        check("clear count", 8'h00, err_count);
        step(1'b1, 8'h00, 4'hF, 4'h0, 1'b0, 1'b1);
        check("set wins flags", 8'h05, flags);
        check("set wins count", 8'h01, err_count);
        step(1'b1, 8'h00, 4'hF, 4'h0, 1'b0, 1'b0);
        repeat (300) @(posedge ref_clk_i);
        #1;
        check("saturated count", 8'hFF, err_count);
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic conclude();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Main sequence: reset for three cycles, then each scenario in turn.
    initial
    begin
        repeat (3) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        #1;
        check("reset flags", 8'h00, flags);
        check("reset count", 8'h00, err_count);
        one_hot_sweep();
        polarity_toggle();
        forbidden_patterns();
        status_clear();
        conclude();
    end
endmodule

// ---- bench/upstream_model.sv ----
// Upstream logic model: drives the select and data lines of the multiplexer.
// Assumes the bench changes its requests by non-blocking assignment at a rising edge.
`timescale 1ns/1ps
module upstream_model #(
    parameter int LANES = 4
) (
    input wire logic [7:0] lane_i,
    input wire logic break_i,
    input wire logic [LANES-1:0] raw_sel_i,
    input wire logic [LANES-1:0] word_i,
    output logic [LANES-1:0] sel_o,
    output logic [LANES-1:0] data_o
);
    // Exactly one select is high unless a scenario asks for a forbidden pattern.
    always_comb
    begin
        sel_o = break_i ? raw_sel_i : LANES'(1) << lane_i;
        data_o = word_i;
    end
endmodule

// ---- hdl/one_hot_decode.sv ----
// Combinational core of the one-hot multiplexer: AND-OR path and select pattern check.
// Assumes the lane count has already been checked by the instantiating module.
`timescale 1ns/1ps
module one_hot_decode #(
    parameter int LANES = one_hot_select_pkg::DEFAULT_LANES
) (
    input wire logic [LANES-1:0] sel_i,
    input wire logic [LANES-1:0] data_i,
    input wire logic invert_i,
    output logic forbidden_combo_function_o,
    output logic none_active_o,
    output logic many_active_o,
    output logic output_function_o
);

    logic [LANES:0] seen_any;
    logic [LANES:0] seen_many;
    logic [LANES:0] or_chain;

    // Each lane adds its product term and notes whether a lower lane was already selected.
    // A ripple chain keeps the pair check linear in the lane count instead of quadratic.
    assign seen_any[0] = 1'b0;
    assign seen_many[0] = 1'b0;
    assign or_chain[0] = 1'b0;
    for (genvar i = 0; i < LANES; i++)
    begin : g_lane
        assign seen_any[i+1] = seen_any[i] | sel_i[i];
        assign seen_many[i+1] = seen_many[i] | (seen_any[i] & sel_i[i]);
        assign or_chain[i+1] = or_chain[i] | (sel_i[i] & data_i[i]);
    end

    // With a one-hot select, inverting the whole result equals inverting every data input at once.
    assign none_active_o = ~seen_any[LANES];
    assign many_active_o = seen_many[LANES];
    assign forbidden_combo_function_o = none_active_o | many_active_o;
    assign output_function_o = or_chain[LANES] ^ invert_i;

endmodule

// ---- hdl/one_hot_select_mux.sv ----
// Top of the one-hot select multiplexer with registered result and pattern status.
// Assumes select, data and polarity inputs are synchronous to ref_clk_i.
`timescale 1ns/1ps
module one_hot_select_mux #(
    parameter int LANES = one_hot_select_pkg::DEFAULT_LANES
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic [LANES-1:0] sel_i,
    input wire logic [LANES-1:0] data_i,
    input wire logic invert_i,
    input wire logic clear_status_i,
    output logic mux_out_o,
    output logic out_defined_o,
    output logic contention_o,
    output logic none_seen_o,
    output logic many_seen_o,
    output logic [one_hot_select_pkg::ERR_CNT_W-1:0] err_count_o
);

    // A single lane is a wire, not a multiplexer, and the pair check would be empty.
    if (LANES < one_hot_select_pkg::MIN_LANES)
    begin : g_lane_check
        $error("one_hot_select_mux needs at least two lanes");
    end

    one_hot_select_pkg::mux_state_t state_reg;
    one_hot_select_pkg::mux_state_t state_next;
    logic forbidden;
    logic none_active;
    logic many_active;
    logic out_func;

    // Equal select and data widths come from the single LANES parameter.
    one_hot_decode #(
        .LANES(LANES)
    ) u_decode (
        .sel_i(sel_i),
        .data_i(data_i),
        .invert_i(invert_i),
        .forbidden_combo_function_o(forbidden),
        .none_active_o(none_active),
        .many_active_o(many_active),
        .output_function_o(out_func)
    );

    // Next state: the result is always computed, but only called defined on a one-hot pattern.
    // A new forbidden pattern in the clearing cycle still sets the sticky bits.
    always_comb
    begin
        state_next = state_reg;
        state_next.mux_out = out_func;
        state_next.out_defined = ~forbidden;
        state_next.contention = forbidden;
        case ({many_active, none_active})
            2'b01:
            begin
                state_next.sel_class = one_hot_select_pkg::SEL_NONE;
            end
            2'b10, 2'b11:
            begin
                state_next.sel_class = one_hot_select_pkg::SEL_MANY;
            end
            default:
            begin
                state_next.sel_class = one_hot_select_pkg::SEL_ONE_HOT;
            end
        endcase
        if (clear_status_i)
        begin
            state_next.none_seen = one_hot_select_pkg::RESET_FLAG;
            state_next.many_seen = one_hot_select_pkg::RESET_FLAG;
            state_next.err_count = one_hot_select_pkg::RESET_ERR_CNT;
        end
        if (none_active)
        begin
            state_next.none_seen = 1'b1;
        end
        if (many_active)
        begin
            state_next.many_seen = 1'b1;
        end
        if (forbidden)
        begin
            if (clear_status_i)
            begin
                state_next.err_count = 8'h01;
            end
            else if (state_reg.err_count != one_hot_select_pkg::ERR_CNT_MAX)
            begin
                state_next.err_count = state_reg.err_count + 8'h01;
            end
        end
    end

    // State register with synchronous reset.
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            state_reg.mux_out <= one_hot_select_pkg::RESET_MUX_OUT;
            state_reg.out_defined <= one_hot_select_pkg::RESET_DEFINED;
            state_reg.contention <= one_hot_select_pkg::RESET_FLAG;
            state_reg.sel_class <= one_hot_select_pkg::SEL_ONE_HOT;
            state_reg.none_seen <= one_hot_select_pkg::RESET_FLAG;
            state_reg.many_seen <= one_hot_select_pkg::RESET_FLAG;
            state_reg.err_count <= one_hot_select_pkg::RESET_ERR_CNT;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // One result output plus status; every output comes straight from the state register.
    assign mux_out_o = state_reg.mux_out;
    assign out_defined_o = state_reg.out_defined;
    assign contention_o = state_reg.contention;
    assign none_seen_o = state_reg.none_seen;
    assign many_seen_o = state_reg.many_seen;
    assign err_count_o = state_reg.err_count;

    // The registered result follows the AND-OR of the previous cycle's inputs.
    a_mux_and_or: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        !$past(reset_i) |-> mux_out_o == ((|($past(sel_i) & $past(data_i))) ^ $past(invert_i)))
    else $error("mux output differs from AND-OR of inputs");

    // On a one-hot pattern the output is the chosen lane's data, inverted when invert_i was high.
    a_one_hot_pick: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        $onehot(sel_i) |=> out_defined_o && mux_out_o == ($past(|(sel_i & data_i)) ^ $past(invert_i)))
    else $error("one-hot output is not the selected data");

    // No select high leaves the output marked undefined in the next cycle.
    a_none_undefined: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        (sel_i == '0) |=> !out_defined_o && none_seen_o && state_reg.sel_class == one_hot_select_pkg::SEL_NONE)
    else $error("empty select not reported as undefined");

    // Two or more selects mark the output unreliable and set the sticky bit.
    a_many_unreliable: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        ($countones(sel_i) > 1) |=> !out_defined_o && many_seen_o
            && state_reg.sel_class == one_hot_select_pkg::SEL_MANY)
    else $error("multiple selects not reported as contention");

    // The forbidden check looks at selects only, whatever the data does.
    a_forbid_sel_only: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        forbidden == !$onehot(sel_i))
    else $error("forbidden check disagrees with select pattern");

    // The contention flag tracks the forbidden function with one cycle of delay.
    a_flag_follows: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        !$past(reset_i) |-> contention_o == !$past($onehot(sel_i)) && contention_o == !out_defined_o)
    else $error("contention flag does not follow select pattern");

    // Toggling polarity with unchanged inputs flips the defined output and nothing else.
    a_polarity_whole: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        $onehot(sel_i) && $stable(sel_i) && $stable(data_i) && $changed(invert_i) && !$past(reset_i)
        |=> mux_out_o != $past(mux_out_o))
    else $error("polarity change did not invert the output");

    // A forbidden pattern held for three cycles grows the error count by three.
    a_err_count_step: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        (forbidden && !clear_status_i && err_count_o < 8'hF0) [*3]
        |=> err_count_o == $past(err_count_o, 3) + 8'h03)
    else $error("error count did not step with forbidden cycles");

    // A forbidden pattern in the clearing cycle keeps its sticky bit set.
    a_set_over_clear: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        clear_status_i && many_active |=> many_seen_o && err_count_o == 8'h01)
    else $error("clear won over a simultaneous contention event");

    // A clear on a legal cycle empties all status in the next cycle.
    a_clear_status: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        clear_status_i && !forbidden |=> !none_seen_o && !many_seen_o
            && err_count_o == one_hot_select_pkg::RESET_ERR_CNT)
    else $error("status not cleared after a legal clear cycle");

    // A legal cycle without a clear leaves the error count alone.
    a_count_hold: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        !forbidden && !clear_status_i |=> err_count_o == $past(err_count_o))
    else $error("error count moved on a legal cycle");

    // The count stops at its ceiling, so a long fault never reads back as a small number.
    a_count_saturate: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        forbidden && !clear_status_i && err_count_o == one_hot_select_pkg::ERR_CNT_MAX
        |=> err_count_o == one_hot_select_pkg::ERR_CNT_MAX)
    else $error("error count wrapped past its ceiling");

    // The empty-select status bit holds until a clear, whatever the selects do.
    a_none_sticky: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        none_seen_o && !clear_status_i |=> none_seen_o)
    else $error("none-seen status dropped without a clear");

    // The many-seen status bit holds until a clear, whatever the selects do.
    a_many_sticky: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        many_seen_o && !clear_status_i |=> many_seen_o)
    else $error("many-seen status dropped without a clear");

endmodule

// ---- inc/one_hot_select_pkg.sv ----
// Shared constants and the state type of the one-hot select multiplexer.
// Assumes every user refers to these names through the package scope.
package one_hot_select_pkg;

    // Number of select/data pairs unless the instantiating logic says otherwise.
    localparam int DEFAULT_LANES = 4;

    // Smallest lane count that still makes the cell a multiplexer.
    localparam int MIN_LANES = 2;

    // Width of the saturating count of cycles that saw a forbidden pattern.
    localparam int ERR_CNT_W = 8;

    // Reset values of the registered state, and the ceiling of the error count.
    localparam logic RESET_MUX_OUT = 1'b0;
    localparam logic RESET_DEFINED = 1'b0;
    localparam logic RESET_FLAG = 1'b0;
    localparam logic [ERR_CNT_W-1:0] RESET_ERR_CNT = 8'h00;
    localparam logic [ERR_CNT_W-1:0] ERR_CNT_MAX = 8'hFF;

    // Classification of the select pattern seen in one cycle.
    typedef enum logic [1:0] {
        SEL_ONE_HOT = 2'b00,
        SEL_NONE = 2'b01,
        SEL_MANY = 2'b11
    } sel_class_t;

    // Everything the top module remembers, registered as one word.
    typedef struct packed {
        logic mux_out;
        logic out_defined;
        logic contention;
        sel_class_t sel_class;
        logic none_seen;
        logic many_seen;
        logic [ERR_CNT_W-1:0] err_count;
    } mux_state_t;

endpackage
